// ---- hw/svtd_top.sv ----
// supply voltage trip detect control and flag logic
// ==================================================
`include "svtd_defs.svh"

module svtd_top #(
  parameter int STARTUP_CYC = `SVTD_STARTUP_CYC
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic SLEEP,
  input wire logic CMP_RISE_IN,
  input wire logic BGAP_OK_IN,
  output logic [7:0] RDATA,
  output logic [3:0] TRIP_LEVEL,
  output logic USE_EXT_INPUT,
  output logic DET_POWER,
  output logic IRQ,
  output logic WAKE
);
  // ==================================================
  // declarations
  logic dir;
  logic en;
  logic [3:0] level;
  logic ref_stable;
  logic bg_stable;
  logic [7:0] gctrl;
  logic trip_flag;
  logic trip_ie;
  logic trip_prio;
  logic ev_mask;
  logic cmp_prev;
  logic [31:0] settle_cnt;
  svtd_pkg::svtd_state_t state;
  svtd_pkg::svtd_state_t next_state;
  svtd_sync_if sif ();

  // comparator reports supply above tap; bandgap ok rides on the second lane
  assign sif.raw_cmp = CMP_RISE_IN;
  assign sif.raw_ext = BGAP_OK_IN;

  svtd_sync u_sync (
    .clk(CORE_CLK),
    .nrst(NRST),
    .s(sif)
  );

  // ==================================================
  // register decode
  // unmapped addresses read as zero and ignore writes
  wire wr_ctrl = WR && (ADDR == `SVTD_OFS_CTRL);
  wire wr_gctrl = WR && (ADDR == `SVTD_OFS_GCTRL);
  wire wr_flags = WR && (ADDR == `SVTD_OFS_FLAGS);
  wire wr_enab = WR && (ADDR == `SVTD_OFS_ENAB);
  wire wr_prio = WR && (ADDR == `SVTD_OFS_PRIO);
  wire wr_evmask = WR && (ADDR == `SVTD_OFS_EVMASK);
  wire [7:0] ctrl_rd = {dir, bg_stable, ref_stable, en, level};
  wire [7:0] flags_rd = {5'h00, trip_flag, 2'h0};
  wire [7:0] enab_rd = {5'h00, trip_ie, 2'h0};
  wire [7:0] prio_rd = {5'h00, trip_prio, 2'h0};
  wire [7:0] evmask_rd = {5'h00, ev_mask, 2'h0};
  wire [7:0] next_rdata =
    (ADDR == `SVTD_OFS_CTRL) ? ctrl_rd :
    (ADDR == `SVTD_OFS_GCTRL) ? gctrl :
    (ADDR == `SVTD_OFS_FLAGS) ? flags_rd :
    (ADDR == `SVTD_OFS_ENAB) ? enab_rd :
    (ADDR == `SVTD_OFS_PRIO) ? prio_rd :
    (ADDR == `SVTD_OFS_EVMASK) ? evmask_rd : 8'h00;

  // ==================================================
  // crossing detection; direction picks the edge of the comparator level
  // edge based: a supply already past the trip point at enable raises nothing
  wire cmp_now = sif.cmp;
  wire rise_hit = dir && cmp_now && !cmp_prev;
  wire fall_hit = !dir && !cmp_now && cmp_prev;
  wire armed = (state == svtd_pkg::SVTD_ARMED);
  wire trip_event = armed && (rise_hit || fall_hit);
  wire clr_flag = wr_flags && WDATA[`SVTD_BIT_TRIP];
  // set wins over a write-one clear in the same cycle
  wire next_flag = trip_event || (trip_flag && !clr_flag);
  wire next_irq = trip_flag && ev_mask && trip_ie && gctrl[`SVTD_BIT_GIE];
  wire settle_done = (settle_cnt >= (STARTUP_CYC - 1));

  // ==================================================
  // stabilisation sequence, runs off a fixed-time count
  always_comb begin
    next_state = state;
    case (state)
      svtd_pkg::SVTD_OFF: begin
        if (en) begin
          next_state = svtd_pkg::SVTD_SETTLE;
        end
      end
      svtd_pkg::SVTD_SETTLE: begin
        if (!en) begin
          next_state = svtd_pkg::SVTD_OFF;
        end else if (settle_done) begin
          next_state = svtd_pkg::SVTD_ARMED;
        end
      end
      svtd_pkg::SVTD_ARMED: begin
        if (!en) begin
          next_state = svtd_pkg::SVTD_OFF;
        end
      end
      default: begin
        next_state = svtd_pkg::SVTD_OFF;
      end
    endcase
  end

  // ==================================================
  // state and settle counter
  // the count only runs in settle, so a disable mid-count starts it over
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= svtd_pkg::SVTD_OFF;
      settle_cnt <= 32'h0;
    end else begin
      state <= next_state;
      settle_cnt <= (state == svtd_pkg::SVTD_SETTLE) ? settle_cnt + 32'h1 : 32'h0;
    end
  end

  // ==================================================
  // control register; reset leaves the detector off
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      dir <= 1'b0;
      en <= 1'b0;
      level <= `SVTD_RST_LEVEL;
    end else if (wr_ctrl) begin
      dir <= WDATA[`SVTD_BIT_DIR];
      en <= WDATA[`SVTD_BIT_EN];
      level <= WDATA[3:0];
    end
  end

  // ==================================================
  // status bits; stable only while enabled, so a re-enable waits again
  // bandgap status is only shown while the detector is powered
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ref_stable <= 1'b0;
      bg_stable <= 1'b0;
      cmp_prev <= 1'b0;
    end else begin
      ref_stable <= (next_state == svtd_pkg::SVTD_ARMED);
      bg_stable <= en && sif.ext;
      cmp_prev <= cmp_now;
    end
  end

  // ==================================================
  // interrupt registers
  // priority bit is plain storage; this block drives a single interrupt line
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      gctrl <= 8'h00;
      trip_flag <= 1'b0;
      trip_ie <= 1'b0;
      trip_prio <= 1'b0;
      ev_mask <= 1'b1;
    end else begin
      trip_flag <= next_flag;
      if (wr_gctrl) begin
        gctrl <= WDATA;
      end
      if (wr_enab) begin
        trip_ie <= WDATA[`SVTD_BIT_TRIP];
      end
      if (wr_prio) begin
        trip_prio <= WDATA[`SVTD_BIT_TRIP];
      end
      if (wr_evmask) begin
        ev_mask <= WDATA[`SVTD_BIT_TRIP];
      end
    end
  end

  // ==================================================
  // registered outputs; wake ignores the global enable on purpose
  // every output is a level except RDATA, a one-cycle answer to a read
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 8'h00;
      TRIP_LEVEL <= `SVTD_RST_LEVEL;
      USE_EXT_INPUT <= 1'b0;
      DET_POWER <= 1'b0;
      IRQ <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      RDATA <= RD ? next_rdata : 8'h00;
      TRIP_LEVEL <= level;
      USE_EXT_INPUT <= (level == `SVTD_LEVEL_EXT);
      DET_POWER <= en;
      IRQ <= next_irq;
      WAKE <= SLEEP && trip_flag && trip_ie;
    end
  end

  // ==================================================
  // check-only age counter of cycles spent enabled; it is kept apart from the
  // sequencer so the start-up check does not lean on the count it checks
  logic [31:0] en_age;
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      en_age <= 32'h0;
    end else begin
      en_age <= en ? en_age + 32'h1 : 32'h0;
    end
  end

  // ==================================================
  // checks on the flag; they watch the sticky bit, not the edge logic
  // an event must reach the flag on the next edge
  a_flag_sets_on_trip: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    trip_event |=> trip_flag
  ) else $error("trip event did not set flag");

  // without a clear the flag stays set
  a_flag_sticks: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    trip_flag && !clr_flag |=> trip_flag
  ) else $error("flag lost without clear");

  // a lone write-one clear drops the flag
  a_flag_clears: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    clr_flag && !trip_event |=> !trip_flag
  ) else $error("flag survived a clear");

  // a new flag needs the reference to have been stable the cycle before
  a_no_early_trip: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    $rose(trip_flag) |-> $past(ref_stable)
  ) else $error("trip before stable");

  // the crossing that set the flag matches the chosen direction
  a_trip_direction: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    $rose(trip_flag) |-> ($past(cmp_now) == $past(dir))
  ) else $error("trip against direction");

  // ==================================================
  // checks on the start-up sequence
  // stable never shows in the first cycles after enable
  a_settle_time: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    $rose(en) |-> !ref_stable [*8]
  ) else $error("stable came too early");

  // stable shows exactly one count past the start-up interval
  a_settle_exit: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    $rose(ref_stable) |-> (en_age == 32'(STARTUP_CYC + 1))
  ) else $error("start-up interval wrong");

  // disabling drops the stable bit
  a_stable_clears: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    !en && !$past(en) |-> !ref_stable
  ) else $error("stable held while disabled");

  // stable is only ever shown for an enabled detector
  a_stable_needs_en: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    ref_stable |-> $past(en)
  ) else $error("stable without enable");

  // ==================================================
  // checks on interrupt and wake
  // both enables must have been set
  a_irq_gated: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    IRQ |-> $past(trip_ie) && $past(gctrl[`SVTD_BIT_GIE])
  ) else $error("irq without enables");

  // the interrupt needs a set, unmasked flag
  a_irq_needs_flag: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    IRQ |-> $past(trip_flag) && $past(ev_mask)
  ) else $error("irq without flag");

  // an enabled flag wakes a sleeping device
  a_wake_on_flag: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    SLEEP && trip_flag && trip_ie |=> WAKE
  ) else $error("no wake in sleep");

  // wake is only raised while asleep
  a_wake_needs_sleep: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    WAKE |-> $past(SLEEP)
  ) else $error("wake while awake");

  // ==================================================
  // checks on the analog controls
  // external input chosen exactly for the all-ones level
  a_ext_select: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    USE_EXT_INPUT == ($past(level) == `SVTD_LEVEL_EXT)
  ) else $error("external input select wrong");

  // the level output copies the level field
  a_level_out: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    TRIP_LEVEL == $past(level)
  ) else $error("level output wrong");

  // power follows the enable bit two edges after the write
  a_power_follows: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    wr_ctrl |=> ##1 DET_POWER == $past(WDATA[`SVTD_BIT_EN], 2)
  ) else $error("power not following enable");

  // sleep never powers the detector down
  a_power_in_sleep: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    en && SLEEP |=> DET_POWER
  ) else $error("detector off in sleep");
endmodule

// ---- hw/svtd_defs.svh ----
// constants for the supply trip detect control block
`ifndef SVTD_DEFS_SVH
`define SVTD_DEFS_SVH
// ==================================================
// register offsets
`define SVTD_OFS_CTRL 8'h00
`define SVTD_OFS_GCTRL 8'h01
`define SVTD_OFS_FLAGS 8'h02
`define SVTD_OFS_ENAB 8'h03
`define SVTD_OFS_PRIO 8'h04
`define SVTD_OFS_EVMASK 8'h05
// ==================================================
// field positions
`define SVTD_BIT_DIR 7
`define SVTD_BIT_BGSTB 6
`define SVTD_BIT_RSTB 5
`define SVTD_BIT_EN 4
`define SVTD_BIT_TRIP 2
`define SVTD_BIT_GIE 7
`define SVTD_LEVEL_EXT 4'hF
// ==================================================
// reset values
`define SVTD_RST_CTRL 8'h04
`define SVTD_RST_ZERO 8'h00
`define SVTD_RST_LEVEL 4'h4
// ==================================================
// timing
`define SVTD_STARTUP_US 20
`define SVTD_CLK_MHZ 100
`define SVTD_STARTUP_CYC (`SVTD_STARTUP_US * `SVTD_CLK_MHZ)
`endif

// ---- hw/svtd_pkg.sv ----
// types shared by the supply trip detect control block
package svtd_pkg;
  typedef enum logic [1:0] {
    SVTD_OFF,
    SVTD_SETTLE,
    SVTD_ARMED
  } svtd_state_t;
endpackage

// ---- hw/svtd_sync_if.sv ----
// interface carrying the raw and synchronised comparator levels
interface svtd_sync_if;
  logic raw_cmp;
  logic raw_ext;
  logic cmp;
  logic ext;
  modport syncer(input raw_cmp, input raw_ext, output cmp, output ext);
  modport user(output raw_cmp, output raw_ext, input cmp, input ext);
endinterface

// ---- hw/svtd_sync.sv ----
// two flop synchroniser for the analog comparator levels
module svtd_sync (
  input wire logic clk,
  input wire logic nrst,
  svtd_sync_if.syncer s
);
  logic [1:0] stage1;
  logic [1:0] stage2;
  // ==================================================
  // first stage only feeds the second stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 2'h0;
      stage2 <= 2'h0;
    end else begin
      stage1 <= {s.raw_ext, s.raw_cmp};
      stage2 <= stage1;
    end
  end
  assign s.cmp = stage2[0];
  assign s.ext = stage2[1];
endmodule

// ---- bench/svtd_top_tb.sv ----
// self-checking bench for the supply trip detect control block
`include "svtd_defs.svh"
module svtd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short start-up count keeps the run brief; settle waits derive from it
  localparam int SC = 10;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep = 1'b0;
  logic cmp = 1'b0;
  logic bgap = 1'b1;
  logic [7:0] rdata;
  logic [3:0] trip_level;
  logic use_ext;
  logic det_power;
  logic irq;
  logic wake;
  logic [7:0] d;
  int n_fail = 0;
  int n_compared = 0;
  svtd_top #(.STARTUP_CYC(SC)) u_svtd_top (.CORE_CLK(core_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .SLEEP(sleep), .CMP_RISE_IN(cmp), .BGAP_OK_IN(bgap), .RDATA(rdata),
    .TRIP_LEVEL(trip_level), .USE_EXT_INPUT(use_ext), .DET_POWER(det_power), .IRQ(irq), .WAKE(wake));
  // ==================================================
  // clock and hang guard
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100us;
    n_fail++;
    $display("mismatch at %0t: run did not finish", $time);
    close_out();
  end
  // ==================================================
  // shared tasks
  task automatic close_out();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // masked compare; unknown bits under the mask never match
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m, input string what);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_irq(input logic e);
    int i;
    for (i = 0; i < 20; i++) begin
      if (irq === e) break;
      @(posedge core_clk);
      #1;
    end
    if (i == 20) begin
      n_fail++;
      $display("mismatch at %0t: irq wait ran out", $time);
      close_out();
    end else begin
      chk({7'h0, irq}, {7'h0, e}, 8'h01, "irq");
    end
  endtask
  // ==================================================
  // scenarios
  task automatic t_reset();
    rd_reg(`SVTD_OFS_CTRL, d);
    chk(d, `SVTD_RST_CTRL, 8'hFF, "ctrl reset");
    chk({4'h0, trip_level}, 8'h04, 8'h0F, "level reset");
    chk({7'h0, det_power}, 8'h00, 8'h01, "power reset");
    rd_reg(8'h10, d);
    chk(d, 8'h00, 8'hFF, "unmapped read");
    wr_reg(`SVTD_OFS_CTRL, 8'h64);
    rd_reg(`SVTD_OFS_CTRL, d);
    chk(d, `SVTD_RST_CTRL, 8'hFF, "status bits read-only");
    rd_reg(`SVTD_OFS_EVMASK, d);
    chk(d, 8'h04, 8'hFF, "event mask reset");
    wr_reg(`SVTD_OFS_GCTRL, 8'h5A);
    rd_reg(`SVTD_OFS_GCTRL, d);
    chk(d, 8'h5A, 8'hFF, "global control");
    wr_reg(`SVTD_OFS_PRIO, 8'hFF);
    rd_reg(`SVTD_OFS_PRIO, d);
    chk(d, 8'h04, 8'hFF, "priority bit");
    wr_reg(`SVTD_OFS_GCTRL, 8'h00);
  endtask
  task automatic t_levels();
    for (int l = 0; l < 16; l++) begin
      wr_reg(`SVTD_OFS_CTRL, 8'(l));
      cycles(2);
      #1;
      chk({4'h0, trip_level}, 8'(l), 8'h0F, "level");
      chk({7'h0, use_ext}, {7'h0, l == 15}, 8'h01, "ext input");
    end
  endtask
  // a rising crossing during the start-up interval must be lost
  task automatic t_holdoff();
    wr_reg(`SVTD_OFS_CTRL, 8'h90);
    @(posedge core_clk);
    cmp <= 1'b1;
    cycles(2);
    cmp <= 1'b0;
    #1 chk({7'h0, det_power}, 8'h01, 8'h01, "power on");
    rd_reg(`SVTD_OFS_CTRL, d);
    chk(d, 8'h00, 8'h20, "stable early");
    cycles(SC + 6);
    rd_reg(`SVTD_OFS_CTRL, d);
    chk(d, 8'hF0, 8'hF0, "stable late");
    @(posedge core_clk);
    bgap <= 1'b0;
    cycles(4);
    rd_reg(`SVTD_OFS_CTRL, d);
    chk(d, 8'hB0, 8'hF0, "bandgap low");
    @(posedge core_clk);
    bgap <= 1'b1;
    rd_reg(`SVTD_OFS_FLAGS, d);
    chk(d, 8'h00, 8'h04, "flag held off");
  endtask
  task automatic t_rise();
    wr_reg(`SVTD_OFS_ENAB, 8'h04);
    wr_reg(`SVTD_OFS_GCTRL, 8'h80);
    wr_reg(`SVTD_OFS_FLAGS, 8'h04);
    @(posedge core_clk);
    cmp <= 1'b1;
    wait_irq(1'b1);
    @(posedge core_clk);
    cmp <= 1'b0;
    cycles(6);
    rd_reg(`SVTD_OFS_FLAGS, d);
    chk(d, 8'h04, 8'h04, "flag sticky");
    wr_reg(`SVTD_OFS_EVMASK, 8'h00);
    wait_irq(1'b0);
    wr_reg(`SVTD_OFS_EVMASK, 8'h04);
    wait_irq(1'b1);
    wr_reg(`SVTD_OFS_GCTRL, 8'h00);
    wait_irq(1'b0);
    wr_reg(`SVTD_OFS_GCTRL, 8'h80);
    wait_irq(1'b1);
    wr_reg(`SVTD_OFS_ENAB, 8'h00);
    wait_irq(1'b0);
    // sleep wake does not depend on the global enable
    @(posedge core_clk);
    sleep <= 1'b1;
    wr_reg(`SVTD_OFS_ENAB, 8'h04);
    wr_reg(`SVTD_OFS_GCTRL, 8'h00);
    cycles(3);
    #1 chk({6'h0, wake, irq}, 8'h02, 8'h03, "wake");
    wr_reg(`SVTD_OFS_FLAGS, 8'h04);
    cycles(3);
    #1 chk({7'h0, wake}, 8'h00, 8'h01, "wake clear");
    @(posedge core_clk);
    sleep <= 1'b0;
  endtask
  // disable around the settings change, then fall mode ignores a rise
  task automatic t_fall();
    wr_reg(`SVTD_OFS_CTRL, 8'h03);
    cycles(2);
    #1 chk({7'h0, det_power}, 8'h00, 8'h01, "power off");
    rd_reg(`SVTD_OFS_CTRL, d);
    chk(d, 8'h03, 8'hFF, "disabled ctrl");
    wr_reg(`SVTD_OFS_CTRL, 8'h13);
    rd_reg(`SVTD_OFS_CTRL, d);
    chk(d, 8'h10, 8'h30, "restart settle");
    cycles(SC + 6);
    @(posedge core_clk);
    cmp <= 1'b1;
    cycles(6);
    rd_reg(`SVTD_OFS_FLAGS, d);
    chk(d, 8'h00, 8'h04, "rise in fall mode");
    wr_reg(`SVTD_OFS_GCTRL, 8'h80);
    @(posedge core_clk);
    cmp <= 1'b0;
    wait_irq(1'b1);
    wr_reg(`SVTD_OFS_FLAGS, 8'h04);
    wait_irq(1'b0);
  endtask
  task automatic t_reset2();
    @(posedge core_clk);
    nrst <= 1'b0;
    cycles(2);
    nrst <= 1'b1;
    rd_reg(`SVTD_OFS_CTRL, d);
    chk(d, `SVTD_RST_CTRL, 8'hFF, "ctrl after reset");
    chk({7'h0, det_power}, 8'h00, 8'h01, "power after reset");
    rd_reg(`SVTD_OFS_GCTRL, d);
    chk(d, 8'h00, 8'hFF, "global control after reset");
  endtask
  // ==================================================
  // main sequence
  initial begin
    cycles(2);
    nrst <= 1'b1;
    t_reset();
    t_levels();
    t_holdoff();
    t_rise();
    t_fall();
    t_reset2();
    close_out();
  end
endmodule
